// [rtl/ctl_io_pkg.sv]
// shared constants and carriers for the control i/o block
package ctl_io_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [4:0] CFG_ADDR = 5'h00;
  localparam logic [4:0] JUDGE_ADDR = 5'h04;
  localparam logic [4:0] DMAX_ADDR = 5'h08;
  localparam logic [4:0] CTRL_ADDR = 5'h0c;
  localparam logic [4:0] STATUS_ADDR = 5'h10;
  localparam logic [4:0] COUNT_ADDR = 5'h14;

  // ----------------------------------------------------------------
  // configuration fields
  // ----------------------------------------------------------------
  localparam int CFG_TWO_PHASE = 0;
  localparam int CFG_DAC_CURRENT = 1;
  localparam int CFG_WORK_EXT = 2;
  localparam int CFG_ZONE_EXT = 3;
  localparam int CFG_BEGIN_EXT = 4;
  localparam int CFG_END_EXT = 5;
  localparam int CFG_LEVEL_STYLE = 6;
  localparam int CFG_ZONE_EN_LSB = 8;
  localparam int CFG_WORK_LSB = 16;
  localparam logic [31:0] CFG_RESET = 32'h0000_1f00;

  // control strobe bits
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_DISP_ZERO = 2;

  // status fields
  localparam int ST_RUN = 0;
  localparam int ST_DONE = 1;
  localparam int ST_CONT = 2;
  localparam int ST_UNIT_FAULT = 3;
  localparam int ST_SENSOR_FAULT = 4;
  localparam int ST_WORK_LSB = 8;
  localparam int ST_ZONE_LSB = 16;
  localparam int ST_PINS_LSB = 19;

  // ----------------------------------------------------------------
  // sizes, limits and timing
  // ----------------------------------------------------------------
  localparam int ZONES = 5;
  localparam int WORK_W = 4;
  localparam int SAMPLE_W = 24;
  localparam int JUDGE_W = 11;
  localparam logic [23:0] RANGE_UVV = 24'h000c80;
  localparam logic [23:0] DMAX_RESET = 24'h01869f;
  localparam int CLK_NS = 25;
  localparam int FILTER_NS = 500;
  localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic backlight;
    logic touch_lock;
    logic restart;
    logic [3:0] work;
    logic zone;
    logic clear;
    logic inhibit;
    logic start_stop;
    logic disp_zero;
    logic dig_zero;
  } ctl_pins_t;

  typedef struct packed {
    logic band_hi;
    logic band_ok;
    logic band_lo;
    logic high_high_limit;
    logic load_hi;
    logic load_ok;
    logic load_lo;
    logic low_low_limit;
    logic disp_hi;
    logic disp_ok;
    logic disp_lo;
  } judge_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b01,
    MS_RUN = 2'b10
  } meas_state_t;

endpackage : ctl_io_pkg

// [rtl/pin_filter.sv]
// three-stage synchroniser with stability filter for external pins
`timescale 1ns/1ps
module pin_filter #(
  parameter int W = 1,
  parameter int STABLE = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  localparam int CW = $clog2(STABLE + 1);

  if (W < 1 || STABLE < 1) begin : g_chk
    $error("pin_filter: W and STABLE must be at least 1");
  end

  logic [W-1:0] s1_q, s2_q, s3_q;
  logic [CW-1:0] cnt_q [W];

  // sync chain; open pins rest high, so reset to ones
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else if (ce) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level follows once stages two and three agree for STABLE cycles
  always_ff @(posedge clock) begin
    if (rst) begin
      level <= '1;
      for (int i = 0; i < W; i++) cnt_q[i] <= '0;
    end else if (ce) begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] != s3_q[i] || s3_q[i] == level[i]) begin
          cnt_q[i] <= '0;
        end else if (cnt_q[i] == CW'(STABLE - 1)) begin
          level[i] <= s3_q[i];
          cnt_q[i] <= '0;
        end else begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
        end
      end
    end
  end
endmodule : pin_filter

// [rtl/pulse_counter.sv]
// displacement pulse counter, single phase or quadrature
`timescale 1ns/1ps
module pulse_counter #(
  parameter int CNT_W = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic a_on,
  input wire logic b_on,
  input wire logic two_phase,
  input wire logic zero,
  output logic [CNT_W-1:0] count
);
  if (CNT_W < 2) begin : g_chk
    $error("pulse_counter: CNT_W must be at least 2");
  end

  logic a_q, b_q;

  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] c, input logic up);
    step = up ? c + 1'b1 : c - 1'b1;
  endfunction : step

  // both phases moving in one cycle is illegal, so it is dropped
  always_ff @(posedge clock) begin
    if (rst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      count <= '0;
    end else if (ce) begin
      a_q <= a_on;
      b_q <= b_on;
      if (zero) begin
        count <= '0;
      end else if (!two_phase) begin
        if (a_on && !a_q) count <= step(count, 1'b1);
      end else if (a_on != a_q && b_on == b_q) begin
        count <= step(count, a_on != b_on);
      end else if (b_on != b_q && a_on == a_q) begin
        count <= step(count, a_on == b_on);
      end
    end
  end

  single_up_a: assert property (@(posedge clock) disable iff (rst)
    ce && !zero && !two_phase && a_on && !a_q |=> count == $past(count) + 1'b1)
    else $error("single phase count did not step up");

  quad_dir_a: assert property (@(posedge clock) disable iff (rst)
    ce && !zero && two_phase && a_on && !a_q && !b_on && !b_q
    |=> count == $past(count) + 1'b1)
    else $error("quadrature count did not step up with a leading");
endmodule : pulse_counter

// [rtl/control_io_pulse_counter.sv]
// control i/o top: pin conditioning, judgment drive, measurement control
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - pulse pin high is off, low on
// - single phase counts up on a turning on
// - two phase counts on every edge of either, not of both at once
// - one setting picks voltage or current output
// - unit fault when bridge exceeds range
// - sensor fault when beyond display maximum
// - done once measurement ends and ready again
// - band and zone judgments on their outputs
// - backlight lit while its input is on
// - touch ignored while lockout input is on
// - restart input restarts the unit
// - work pins used only when source external
// - work pins binary weighted, number is code+1
// - zone pin steps among enabled zones only
// - clear empties judgments, starts continuous judging
// - inhibit forces all judgment outputs off
// - start/stop pin acts only when selected
// - edge style toggles on each turn-on
// - level style runs while the pin on
// - displacement zero input zeroes the count
// - digital zero input zeroes the load
module control_io_pulse_counter #(
  parameter int CNT_W = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ctl_io_pkg::ADDR_W-1:0] addr,
  input wire logic [ctl_io_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [ctl_io_pkg::DATA_W-1:0] rdata,
  input wire ctl_io_pkg::ctl_pins_t pin_ctl,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic signed [ctl_io_pkg::SAMPLE_W-1:0] bridge_uvv,
  input wire logic signed [ctl_io_pkg::SAMPLE_W-1:0] load_value,
  output logic unit_fault,
  output logic sensor_fault,
  output logic meas_done,
  output logic measuring,
  output ctl_io_pkg::judge_t judge_out,
  output logic cont_judge,
  output logic backlight_on,
  output logic touch_lock,
  output logic restart_pulse,
  output logic load_zero_pulse,
  output logic [ctl_io_pkg::WORK_W:0] work_num,
  output logic [2:0] zone_num,
  output logic dac_volt_en,
  output logic dac_curr_en,
  output logic [CNT_W-1:0] disp_count
);
  localparam int SW = ctl_io_pkg::SAMPLE_W;
  localparam int WW = ctl_io_pkg::WORK_W;
  localparam int NZ = ctl_io_pkg::ZONES;
  localparam int CTL_W = $bits(ctl_io_pkg::ctl_pins_t);

  if (CNT_W < 2 || CNT_W > ctl_io_pkg::DATA_W) begin : g_chk
    $error("control_io_pulse_counter: CNT_W must be 2 to 32");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [SW-1:0] mag(input logic signed [SW-1:0] v);
    mag = v[SW-1] ? SW'(-v) : SW'(v);
  endfunction : mag

  function automatic logic [WW:0] work_of(input logic [WW-1:0] code);
    work_of = {1'b0, code} + 1'b1;
  endfunction : work_of

  // next enabled zone after the current one, or stay if none
  function automatic logic [2:0] next_zone(input logic [2:0] z, input logic [NZ-1:0] en);
    logic [2:0] c;
    next_zone = z;
    c = z;
    for (int i = 0; i < NZ; i++) begin
      c = (c == 3'(NZ - 1)) ? 3'h0 : c + 3'h1;
      if (en[c] && next_zone == z) next_zone = c;
    end
  endfunction : next_zone

  // ----------------------------------------------------------------
  // pin conditioning
  // ----------------------------------------------------------------
  ctl_io_pkg::ctl_pins_t ctl_lvl;
  ctl_io_pkg::ctl_pins_t ctl_on;
  ctl_io_pkg::ctl_pins_t ctl_prev_q;
  ctl_io_pkg::ctl_pins_t ctl_rise;
  ctl_io_pkg::ctl_pins_t ctl_fall;
  logic [1:0] pulse_lvl;
  logic a_on, b_on;

  // control pins get the long filter; contacts may bounce
  pin_filter #(.W(CTL_W), .STABLE(ctl_io_pkg::FILTER_CYC)) u_ctl_filter (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .pin(pin_ctl),
    .level(ctl_lvl)
  );

  // pulse pins only synchronised, a long filter would eat counts
  pin_filter #(.W(2), .STABLE(1)) u_pulse_filter (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .pin({pin_a, pin_b}),
    .level(pulse_lvl)
  );

  // pins are pulled to common_return when asserted, so low is on
  assign ctl_on = ~ctl_lvl;
  assign a_on = ~pulse_lvl[1];
  assign b_on = ~pulse_lvl[0];

  // edge detection on the filtered levels
  always_ff @(posedge clock) begin
    if (rst) ctl_prev_q <= '0;
    else if (ce) ctl_prev_q <= ctl_on;
  end

  assign ctl_rise = ctl_on & ~ctl_prev_q;
  assign ctl_fall = ~ctl_on & ctl_prev_q;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] cfg_q;
  ctl_io_pkg::judge_t judge_q;
  logic [SW-1:0] dmax_q;
  logic wr_cfg, wr_judge, wr_dmax, wr_ctrl;
  logic sw_start, sw_stop, sw_disp_zero;

  assign wr_cfg = wr && addr == ctl_io_pkg::CFG_ADDR;
  assign wr_judge = wr && addr == ctl_io_pkg::JUDGE_ADDR;
  assign wr_dmax = wr && addr == ctl_io_pkg::DMAX_ADDR;
  assign wr_ctrl = wr && addr == ctl_io_pkg::CTRL_ADDR;
  assign sw_start = wr_ctrl && wdata[ctl_io_pkg::CTRL_START];
  assign sw_stop = wr_ctrl && wdata[ctl_io_pkg::CTRL_STOP];
  assign sw_disp_zero = wr_ctrl && wdata[ctl_io_pkg::CTRL_DISP_ZERO];

  // configuration word
  always_ff @(posedge clock) begin
    if (rst) cfg_q <= ctl_io_pkg::CFG_RESET;
    else if (ce && wr_cfg) cfg_q <= wdata;
  end

  // display maximum used for the sensor fault
  always_ff @(posedge clock) begin
    if (rst) dmax_q <= ctl_io_pkg::DMAX_RESET;
    else if (ce && wr_dmax) dmax_q <= wdata[SW-1:0];
  end

  // judgments from the measurement core; the clear pin beats a write
  always_ff @(posedge clock) begin
    if (rst) judge_q <= '0;
    else if (ce && ctl_rise.clear) judge_q <= '0;
    else if (ce && wr_judge) judge_q <= wdata[ctl_io_pkg::JUDGE_W-1:0];
  end

  // ----------------------------------------------------------------
  // measurement start and stop
  // ----------------------------------------------------------------
  ctl_io_pkg::meas_state_t st_q, st_d;
  logic begin_ext, end_ext, level_style, ext_stop;

  assign begin_ext = cfg_q[ctl_io_pkg::CFG_BEGIN_EXT];
  assign end_ext = cfg_q[ctl_io_pkg::CFG_END_EXT];
  assign level_style = cfg_q[ctl_io_pkg::CFG_LEVEL_STYLE];
  // edge style stops on the next turn-on, level style on turn-off
  assign ext_stop = level_style ? ctl_fall.start_stop : ctl_rise.start_stop;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ctl_io_pkg::MS_IDLE: begin
        if (sw_start || (begin_ext && ctl_rise.start_stop)) st_d = ctl_io_pkg::MS_RUN;
      end
      ctl_io_pkg::MS_RUN: begin
        if (sw_stop || (end_ext && ext_stop)) st_d = ctl_io_pkg::MS_IDLE;
      end
      default: st_d = ctl_io_pkg::MS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) st_q <= ctl_io_pkg::MS_IDLE;
    else if (ce) st_q <= st_d;
  end

  // done rises when a run ends and clears when the next one starts
  always_ff @(posedge clock) begin
    if (rst) begin
      meas_done <= 1'b0;
      measuring <= 1'b0;
    end else if (ce) begin
      measuring <= st_d == ctl_io_pkg::MS_RUN;
      if (st_q == ctl_io_pkg::MS_RUN && st_d == ctl_io_pkg::MS_IDLE) meas_done <= 1'b1;
      else if (st_d == ctl_io_pkg::MS_RUN) meas_done <= 1'b0;
    end
  end

  // continuous judging starts on clear and ends with a new run
  always_ff @(posedge clock) begin
    if (rst) cont_judge <= 1'b0;
    else if (ce && ctl_rise.clear) cont_judge <= 1'b1;
    else if (ce && st_d == ctl_io_pkg::MS_RUN && st_q == ctl_io_pkg::MS_IDLE)
      cont_judge <= 1'b0;
  end

  // ----------------------------------------------------------------
  // judgment and fault outputs
  // ----------------------------------------------------------------
  // inhibit and clear both mask, so no stale result leaks out
  always_ff @(posedge clock) begin
    if (rst) judge_out <= '0;
    else if (ce && (ctl_on.inhibit || ctl_rise.clear)) judge_out <= '0;
    else if (ce) judge_out <= judge_q;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      unit_fault <= 1'b0;
      sensor_fault <= 1'b0;
    end else if (ce) begin
      unit_fault <= mag(bridge_uvv) > ctl_io_pkg::RANGE_UVV;
      sensor_fault <= mag(load_value) > dmax_q;
    end
  end

  // one setting steers both enables, so they never overlap
  always_ff @(posedge clock) begin
    if (rst) begin
      dac_volt_en <= 1'b1;
      dac_curr_en <= 1'b0;
    end else if (ce) begin
      dac_curr_en <= cfg_q[ctl_io_pkg::CFG_DAC_CURRENT];
      dac_volt_en <= !cfg_q[ctl_io_pkg::CFG_DAC_CURRENT];
    end
  end

  // ----------------------------------------------------------------
  // panel, restart and zero commands
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      backlight_on <= 1'b0;
      touch_lock <= 1'b0;
      restart_pulse <= 1'b0;
      load_zero_pulse <= 1'b0;
    end else if (ce) begin
      backlight_on <= ctl_on.backlight;
      touch_lock <= ctl_on.touch_lock;
      restart_pulse <= ctl_rise.restart;
      load_zero_pulse <= ctl_rise.dig_zero;
    end
  end

  // ----------------------------------------------------------------
  // work and zone selection
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) work_num <= work_of('0);
    else if (ce && cfg_q[ctl_io_pkg::CFG_WORK_EXT]) work_num <= work_of(ctl_on.work);
    else if (ce) work_num <= work_of(cfg_q[ctl_io_pkg::CFG_WORK_LSB +: WW]);
  end

  // one step per turn-on; a zone with judging off is skipped
  always_ff @(posedge clock) begin
    if (rst) zone_num <= '0;
    else if (ce && cfg_q[ctl_io_pkg::CFG_ZONE_EXT] && ctl_rise.zone)
      zone_num <= next_zone(zone_num, cfg_q[ctl_io_pkg::CFG_ZONE_EN_LSB +: NZ]);
  end

  // ----------------------------------------------------------------
  // displacement counter
  // ----------------------------------------------------------------
  pulse_counter #(.CNT_W(CNT_W)) u_counter (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .a_on(a_on),
    .b_on(b_on),
    .two_phase(cfg_q[ctl_io_pkg::CFG_TWO_PHASE]),
    .zero(ctl_rise.disp_zero || sw_disp_zero),
    .count(disp_count)
  );

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [31:0] status;

  always_comb begin
    status = '0;
    status[ctl_io_pkg::ST_RUN] = measuring;
    status[ctl_io_pkg::ST_DONE] = meas_done;
    status[ctl_io_pkg::ST_CONT] = cont_judge;
    status[ctl_io_pkg::ST_UNIT_FAULT] = unit_fault;
    status[ctl_io_pkg::ST_SENSOR_FAULT] = sensor_fault;
    status[ctl_io_pkg::ST_WORK_LSB +: WW + 1] = work_num;
    status[ctl_io_pkg::ST_ZONE_LSB +: 3] = zone_num;
    status[ctl_io_pkg::ST_PINS_LSB +: CTL_W] = ctl_on;
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= '0;
      if (rd) begin
        case (addr)
          ctl_io_pkg::CFG_ADDR: rdata <= cfg_q;
          ctl_io_pkg::JUDGE_ADDR: rdata <= 32'(judge_q);
          ctl_io_pkg::DMAX_ADDR: rdata <= 32'(dmax_q);
          ctl_io_pkg::STATUS_ADDR: rdata <= status;
          ctl_io_pkg::COUNT_ADDR: rdata <= 32'(disp_count);
          default: rdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  dac_select_a: assert property (@(posedge clock) disable iff (rst)
    ce |=> dac_curr_en == $past(cfg_q[ctl_io_pkg::CFG_DAC_CURRENT]) && dac_volt_en != dac_curr_en)
    else $error("analog output enables wrong");

  unit_range_a: assert property (@(posedge clock) disable iff (rst)
    ce |=> unit_fault == (mag($past(bridge_uvv)) > ctl_io_pkg::RANGE_UVV))
    else $error("unit fault does not match bridge range");

  done_after_a: assert property (@(posedge clock) disable iff (rst)
    ce && st_q == ctl_io_pkg::MS_RUN && st_d == ctl_io_pkg::MS_IDLE |=> meas_done && !measuring)
    else $error("done missing after run end");

  clear_judge_a: assert property (@(posedge clock) disable iff (rst)
    ce && ctl_rise.clear |=> judge_out == '0 && cont_judge && judge_q == '0)
    else $error("clear left judgments active");

  inhibit_out_a: assert property (@(posedge clock) disable iff (rst)
    ce && ctl_on.inhibit |=> judge_out == '0)
    else $error("judgment output active under inhibit");

  work_ext_a: assert property (@(posedge clock) disable iff (rst)
    ce && cfg_q[ctl_io_pkg::CFG_WORK_EXT] |=> work_num == {1'b0, $past(ctl_on.work)} + 1'b1)
    else $error("external work number wrong");

  edge_start_a: assert property (@(posedge clock) disable iff (rst)
    ce && !level_style && begin_ext && ctl_rise.start_stop && st_q == ctl_io_pkg::MS_IDLE
    |=> st_q == ctl_io_pkg::MS_RUN ##1 measuring)
    else $error("edge start did not start measurement");

  level_stop_a: assert property (@(posedge clock) disable iff (rst)
    ce && level_style && end_ext && ctl_fall.start_stop && st_q == ctl_io_pkg::MS_RUN
    |=> st_q == ctl_io_pkg::MS_IDLE)
    else $error("level release did not stop measurement");

  backlight_a: assert property (@(posedge clock) disable iff (rst)
    ce |=> backlight_on == $past(ctl_on.backlight) && touch_lock == $past(ctl_on.touch_lock))
    else $error("backlight or touch lock does not follow pin");

  restart_a: assert property (@(posedge clock) disable iff (rst)
    restart_pulse |-> $past(ctl_rise.restart) ##1 !restart_pulse || !ce)
    else $error("restart pulse without cause or too long");
endmodule : control_io_pulse_counter

// [tb/io_partner.sv]
// partner model: controller contacts and pulse sensor outputs
`timescale 1ns/1ps
module io_partner (
  input wire ctl_io_pkg::ctl_pins_t ctl_on,
  input wire logic a_on,
  input wire logic b_on,
  output ctl_io_pkg::ctl_pins_t pin_ctl,
  output logic pin_a,
  output logic pin_b
);
  // closed contact pulls to common return, open pin floats high
  assign pin_ctl = ~ctl_on;
  // sensor phases are low while on
  assign pin_a = ~a_on;
  assign pin_b = ~b_on;
endmodule : io_partner

// [tb/control_io_pulse_counter_tb.sv]
// self-checking bench for the control i/o block
`timescale 1ns/1ps
module control_io_pulse_counter_tb;
  logic clock, rst, ce, wr, rd, a_on, b_on, pin_a, pin_b;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, disp_count;
  logic signed [23:0] bridge_uvv, load_value;
  ctl_io_pkg::ctl_pins_t ctl_on, pin_ctl, nxt;
  ctl_io_pkg::judge_t judge_out;
  logic unit_fault, sensor_fault, meas_done, measuring, cont_judge, backlight_on, touch_lock;
  logic dac_volt_en, dac_curr_en, restart_pulse, load_zero_pulse;
  logic [4:0] work_num;
  logic [2:0] zone_num;
  int num_errors, total_checks, n_restart, n_zero;
  control_io_pulse_counter DUT (.clock(clock), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_ctl(pin_ctl), .pin_a(pin_a),
    .pin_b(pin_b), .bridge_uvv(bridge_uvv), .load_value(load_value),
    .unit_fault(unit_fault), .sensor_fault(sensor_fault), .meas_done(meas_done),
    .measuring(measuring), .judge_out(judge_out), .cont_judge(cont_judge),
    .backlight_on(backlight_on), .touch_lock(touch_lock), .restart_pulse(restart_pulse),
    .load_zero_pulse(load_zero_pulse), .work_num(work_num), .zone_num(zone_num),
    .dac_volt_en(dac_volt_en), .dac_curr_en(dac_curr_en), .disp_count(disp_count));
  io_partner far_side (.ctl_on(ctl_on), .a_on(a_on), .b_on(b_on), .pin_ctl(pin_ctl),
    .pin_a(pin_a), .pin_b(pin_b));
  // 40 mhz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // ends off the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : cyc
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a, input logic [31:0] exp, input string name);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    chk(name, exp, rdata);
  endtask : rd_reg
  // pulse phases have no filter, eight cycles clears the synchroniser
  task automatic step_ab(input logic a, input logic b);
    @(posedge clock);
    a_on <= a;
    b_on <= b;
    cyc(8);
  endtask : step_ab
  // control pins pass sync plus a 20-cycle filter, 30 cycles covers it
  task automatic pins(input ctl_io_pkg::ctl_pins_t v);
    @(posedge clock);
    ctl_on <= v;
    cyc(30);
  endtask : pins
  task automatic wait_run(input logic exp);
    for (int i = 0; i < 60 && measuring !== exp; i++) cyc(1);
    chk("measuring", {31'h0, exp}, {31'h0, measuring});
    if (measuring !== exp) test_done();
  endtask : wait_run
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {ctl_on, nxt, a_on, b_on, addr, wdata, wr, rd, bridge_uvv, load_value} = '0;
    {num_errors, total_checks, n_restart, n_zero} = '0;
    ce = 1'b1;
    rst = 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    cyc(1);
    chk("work_num", 32'h1, {27'h0, work_num});
    chk("dac_en", 32'h1, {30'h0, dac_curr_en, dac_volt_en});
    rd_reg(ctl_io_pkg::CFG_ADDR, ctl_io_pkg::CFG_RESET, "cfg");
    rd_reg(5'h1c, 32'h0, "unmapped");
    wr_reg(ctl_io_pkg::CFG_ADDR, 32'h0000_1f02);
    cyc(2);
    chk("dac_en", 32'h2, {30'h0, dac_curr_en, dac_volt_en});
    // single phase: three a pulses, a b pulse must not count
    for (int i = 0; i < 3; i++) begin
      step_ab(1'b1, 1'b0);
      step_ab(1'b0, 1'b0);
    end
    step_ab(1'b0, 1'b1);
    step_ab(1'b0, 1'b0);
    chk("count_single", 32'h3, disp_count);
    nxt.disp_zero = 1'b1;
    pins(nxt);
    chk("count_zero", 32'h0, disp_count);
    nxt.disp_zero = 1'b0;
    pins(nxt);
    // quadrature: one forward cycle, then two reverse cycles
    wr_reg(ctl_io_pkg::CFG_ADDR, 32'h0000_1f01);
    step_ab(1'b1, 1'b0);
    step_ab(1'b1, 1'b1);
    step_ab(1'b0, 1'b1);
    step_ab(1'b0, 1'b0);
    chk("count_up", 32'h4, disp_count);
    for (int i = 0; i < 2; i++) begin
      step_ab(1'b0, 1'b1);
      step_ab(1'b1, 1'b1);
      step_ab(1'b1, 1'b0);
      step_ab(1'b0, 1'b0);
    end
    chk("count_down", 32'hffff_fffc, disp_count);
    rd_reg(ctl_io_pkg::COUNT_ADDR, 32'hffff_fffc, "count_reg");
    // frozen block drops a write
    @(posedge clock);
    ce <= 1'b0;
    wr_reg(ctl_io_pkg::CTRL_ADDR, 32'h0000_0001);
    ce <= 1'b1;
    cyc(1);
    chk("ce_freeze", 32'h0, {31'h0, measuring});
    // software start with zero, then stop
    wr_reg(ctl_io_pkg::CTRL_ADDR, 32'h0000_0005);
    rd_reg(ctl_io_pkg::STATUS_ADDR, 32'h0000_0101, "status_run");
    chk("count_sw_zero", 32'h0, disp_count);
    wr_reg(ctl_io_pkg::CTRL_ADDR, 32'h0000_0002);
    rd_reg(ctl_io_pkg::STATUS_ADDR, 32'h0000_0102, "status_done");
    // work pins only count while the source is external
    wr_reg(ctl_io_pkg::CFG_ADDR, 32'h0003_1f04);
    nxt.work = 4'h9;
    nxt.backlight = 1'b1;
    nxt.touch_lock = 1'b1;
    pins(nxt);
    chk("work_ext", 32'ha, {27'h0, work_num});
    chk("bl_touch", 32'h3, {30'h0, backlight_on, touch_lock});
    wr_reg(ctl_io_pkg::CFG_ADDR, 32'h0003_1f00);
    nxt = '0;
    pins(nxt);
    chk("work_int", 32'h4, {27'h0, work_num});
    chk("bl_touch", 32'h0, {30'h0, backlight_on, touch_lock});
    // zone steps only among enabled zones 0 and 2
    wr_reg(ctl_io_pkg::CFG_ADDR, 32'h0000_0508);
    nxt.zone = 1'b1;
    pins(nxt);
    chk("zone", 32'h2, {29'h0, zone_num});
    nxt.zone = 1'b0;
    pins(nxt);
    // judgments: inhibit masks, clear empties and starts continuous judging
    wr_reg(ctl_io_pkg::JUDGE_ADDR, 32'h0000_07ff);
    cyc(2);
    chk("judge", 32'h7ff, {21'h0, judge_out});
    nxt.inhibit = 1'b1;
    pins(nxt);
    chk("judge_inh", 32'h0, {21'h0, judge_out});
    nxt.inhibit = 1'b0;
    nxt.clear = 1'b1;
    pins(nxt);
    chk("judge_clr", 32'h0, {21'h0, judge_out});
    chk("cont", 32'h1, {31'h0, cont_judge});
    rd_reg(ctl_io_pkg::JUDGE_ADDR, 32'h0, "judge_reg");
    nxt = '0;
    pins(nxt);
    // start/stop pin ignored unless external, then edge and level styles
    nxt.start_stop = 1'b1;
    pins(nxt);
    chk("no_ext", 32'h0, {31'h0, measuring});
    nxt.start_stop = 1'b0;
    pins(nxt);
    wr_reg(ctl_io_pkg::CFG_ADDR, 32'h0000_1f30);
    nxt.start_stop = 1'b1;
    pins(nxt);
    wait_run(1'b1);
    nxt.start_stop = 1'b0;
    pins(nxt);
    chk("edge_hold", 32'h1, {31'h0, measuring});
    nxt.start_stop = 1'b1;
    pins(nxt);
    wait_run(1'b0);
    chk("done", 32'h1, {31'h0, meas_done});
    nxt.start_stop = 1'b0;
    pins(nxt);
    wr_reg(ctl_io_pkg::CFG_ADDR, 32'h0000_1f70);
    nxt.start_stop = 1'b1;
    pins(nxt);
    wait_run(1'b1);
    nxt.start_stop = 1'b0;
    pins(nxt);
    wait_run(1'b0);
    // one-cycle pulses, sampled every cycle
    nxt.restart = 1'b1;
    nxt.dig_zero = 1'b1;
    @(posedge clock);
    ctl_on <= nxt;
    for (int i = 0; i < 30; i++) begin
      cyc(0);
      n_restart += restart_pulse;
      n_zero += load_zero_pulse;
    end
    chk("restart", 32'h1, n_restart);
    chk("load_zero", 32'h1, n_zero);
    // fault limits at their boundaries
    @(posedge clock);
    bridge_uvv <= 24'h000c80;
    load_value <= 24'h01869f;
    cyc(3);
    chk("faults_in", 32'h0, {30'h0, unit_fault, sensor_fault});
    @(posedge clock);
    bridge_uvv <= 24'hfff37f;
    load_value <= 24'h0186a0;
    cyc(3);
    chk("faults_out", 32'h3, {30'h0, unit_fault, sensor_fault});
    test_done();
  end
endmodule : control_io_pulse_counter_tb
